// ===== sim/jfp_prog.sv
`timescale 1ns/10ps
`default_nettype none
module jfp_prog (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   // tck stands still between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      // released line reads as the inverse of the last bit
      #16 o = tdo_oe_n ? ~tdo : tdo;
      tck = 1'b1;
      #16 tck = 1'b0;
   endtask
   task automatic reset_tap();
      logic o;
      repeat (6) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask
   // from idle back to idle; din repeats every 16 bits, dout keeps the last bits
   task automatic scan(input logic ir, input int n, input logic [15:0] din,
                       output logic [15:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i % 16], o);
         dout = {o, dout[15:1]};
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      if (n < 16) dout = dout >> (16 - n);
   endtask
endmodule // jfp_prog
`default_nettype wire

// ===== sim/jtag_flash_programming_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module jtag_flash_programming_port_test;
   localparam int timeout = 4;
   logic clock, nrst, tck, tms, tdi, tdo, tdo_oe_n, fuse, dis_set, ext_reset_n, dis_bit;
   logic chip_reset, prog_mode, cmd_clk, page_wr, page_rd;
   logic [14:0] flash_cmd, flash_result;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, last_a, last_d;
   logic [15:0] dout;
   int fail_count = 0;
   int n_tests = 0;
   int wr_n = 0;
   int rd_n = 0;
   jfp_port #(.reset_timeout(timeout)) u_dut (.clock(clock), .nrst(nrst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .test_port_enable_fuse(fuse),
      .test_port_disable_set(dis_set), .ext_reset_n(ext_reset_n),
      .test_port_disable_bit(dis_bit), .chip_reset(chip_reset), .prog_mode(prog_mode),
      .flash_cmd(flash_cmd), .flash_cmd_clk(cmd_clk), .flash_result(flash_result),
      .page_wr(page_wr), .page_wr_addr(wr_addr), .page_wr_data(wr_data),
      .page_rd(page_rd), .page_rd_addr(rd_addr), .page_rd_data(rd_data));
   jfp_prog u_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   assign rd_data = rd_addr ^ 8'h5a;
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(negedge tck) begin
      if (page_wr === 1'b1) begin
         wr_n++;
         last_a = wr_addr;
         last_d = wr_data;
      end
      if (page_rd === 1'b1) rd_n++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // bounded wait for chip_reset (sel=1) or the disable bit (sel=0) to drop
   task automatic wait_off(input logic sel, input int bound);
      int k;
      k = 0;
      while ((sel ? chip_reset : dis_bit) !== 1'b0) begin
         @(negedge clock);
         k++;
         if (k > bound) begin
            fail_count++;
            $display("[FAIL] %0t: wait ran out", $time);
            summarize();
         end
      end
   endtask
   task automatic unlock(input logic [15:0] sig);
      u_prog.scan(1'b1, 4, 16'h0004, dout);
      u_prog.scan(1'b0, 16, sig, dout);
   endtask
   task automatic t_gate();
      unlock(16'ha370);
      check(prog_mode, 1'b0);
      @(negedge clock) fuse = 1'b1;
      dis_set = 1'b1;
      @(negedge clock) dis_set = 1'b0;
      repeat (3) @(negedge clock);
      check(dis_bit, 1'b1);
      u_prog.reset_tap();
      unlock(16'ha370);
      check(prog_mode, 1'b0);
      @(negedge clock) ext_reset_n = 1'b0;
      wait_off(1'b0, 8);
      check(dis_bit, 1'b0);
      @(negedge clock) ext_reset_n = 1'b1;
      $display("gate test done");
   endtask
   task automatic t_reset();
      u_prog.reset_tap();
      u_prog.scan(1'b1, 4, 16'h000c, dout);
      u_prog.scan(1'b0, 1, 16'h0001, dout);
      check(chip_reset, 1'b1);
      u_prog.scan(1'b0, 1, 16'h0000, dout);
      repeat (3) @(negedge clock);
      check(chip_reset, 1'b1);
      wait_off(1'b1, 30);
      $display("reset test done");
   endtask
   task automatic t_unlock();
      u_prog.scan(1'b1, 4, 16'h0004, dout);
      check(dout, 16'h0001);
      u_prog.scan(1'b0, 16, 16'ha371, dout);
      check(prog_mode, 1'b0);
      u_prog.scan(1'b1, 4, 16'h0005, dout);
      u_prog.scan(1'b0, 15, 16'h1234, dout);
      check(flash_cmd, 15'h0000);
      unlock(16'ha370);
      check(prog_mode, 1'b1);
      $display("unlock test done");
   endtask
   task automatic t_cmd();
      logic o;
      @(negedge clock) flash_result = 15'h2b1c;
      u_prog.scan(1'b1, 4, 16'h0005, dout);
      u_prog.scan(1'b0, 15, 16'h1234, dout);
      check(dout, 16'h2b1c);
      check(flash_cmd, 15'h1234);
      check(cmd_clk, 1'b1);
      u_prog.step(1'b0, 1'b0, o);
      check(cmd_clk, 1'b0);
      @(negedge clock) flash_result = 15'h0567;
      u_prog.scan(1'b0, 15, 16'h7fff, dout);
      check(dout, 16'h0567);
      check(flash_cmd, 15'h7fff);
      $display("command test done");
   endtask
   task automatic t_pages();
      wr_n = 0;
      u_prog.scan(1'b1, 4, 16'h0006, dout);
      u_prog.scan(1'b0, 2048, 16'hc35a, dout);
      check(16'(wr_n), 16'h0100);
      check(last_a, 8'hff);
      check(last_d, 8'hc3);
      check(flash_cmd, 15'h7fff);
      u_prog.scan(1'b1, 4, 16'h0007, dout);
      rd_n = 0;
      u_prog.scan(1'b0, 2056, 16'hffff, dout);
      check(dout, 16'ha5a4);
      check(16'(rd_n), 16'h0101);
      unlock(16'h0000);
      check(prog_mode, 1'b0);
      $display("page test done");
   endtask
   initial begin
      nrst = 1'b0;
      fuse = 1'b0;
      dis_set = 1'b0;
      ext_reset_n = 1'b1;
      flash_result = 15'h0000;
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      check(prog_mode, 1'b0);
      t_gate();
      t_reset();
      t_unlock();
      t_cmd();
      t_pages();
      summarize();
   end
endmodule // jtag_flash_programming_port_test
`default_nettype wire

// ===== src/jfp_pkg.sv
`default_nettype none
package jfp_pkg;
   localparam int ir_width = 4;
   localparam logic [3:0] ir_chip_reset_instr = 4'hc;
   localparam logic [3:0] ir_program_unlock_instr = 4'h4;
   localparam logic [3:0] ir_program_command_instr = 4'h5;
   localparam logic [3:0] ir_page_fill_instr = 4'h6;
   localparam logic [3:0] ir_page_dump_instr = 4'h7;
   localparam logic [3:0] ir_capture_value = 4'h1;
   localparam int unlock_width = 16;
   localparam logic [15:0] unlock_signature = 16'ha370;
   localparam logic [15:0] unlock_reset = 16'h0000;
   localparam int cmd_width = 15;
   localparam logic [14:0] cmd_reset = 15'h0000;
   localparam int byte_width = 8;
   localparam int page_bits = 2048;
   localparam int page_bytes = page_bits / byte_width;
   localparam int dump_extra_bits = 8;
   localparam int disable_clear_clocks = 2;
   localparam int reset_timeout_default = 64;
   typedef enum logic [3:0] {
      jfp_tlr, jfp_rti, jfp_sel_dr, jfp_cap_dr, jfp_sh_dr, jfp_ex1_dr, jfp_pa_dr,
      jfp_ex2_dr, jfp_up_dr, jfp_sel_ir, jfp_cap_ir, jfp_sh_ir, jfp_ex1_ir,
      jfp_pa_ir, jfp_ex2_ir, jfp_up_ir
   } jfp_tap_t;
endpackage
`default_nettype wire

// ===== src/jfp_port.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: port usable only with enable fuse programmed and disable bit clear.
// R2: disable bit set and external reset low clears the bit two chip clocks later.
// R3: all chains shift lsb first in and out.
// R4: instruction register is four bits, sixteen codes.
// R5: run-test/idle produces internal clocks; also an idle point.
// R6: code c selects one-bit reset chain shifted in shift-dr; tap not reset.
// R7: chip held in reset while reset chain holds one, unlatched, immediate.
// R8: after release, reset extends by a fuse-selected time-out; here set by the reset_timeout parameter.
// R9: code 4 selects sixteen-bit unlock chain receiving signature.
// R10: update-dr compares signature; programming mode only on exact match.
// R11: unlock chain clears on power-on; programmer should clear when leaving.
// R12: code 5 selects fifteen-bit command chain; capture loads previous result.
// R13: shift swaps result out and command in; update applies command.
// R14: each run-test/idle visit under command gives one internal clock.
// R15: code 6 selects 2048-bit virtual page fill chain, 8-bit; no update transfer.
// R16: shift-dr page fill writes each completed byte to page buffer.
// R17: code 7 selects 2056-bit virtual page dump chain, 8-bit; no capture load.
// R18: shift-dr page dump fetches bytes and shifts out, ignoring input.
// R19: programmer uses page chains only when first in scan chain.
// R20: programmer resets device via reset chain before unlocking.
// R21: boundary scan or debug use keeps pins dedicated, no reset re-enable.
// R22: mismatched signature leaves programming off and commands ignored.
module jfp_port #(
   parameter int reset_timeout = jfp_pkg::reset_timeout_default
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic test_port_enable_fuse,
   input wire logic test_port_disable_set,
   input wire logic ext_reset_n,
   output logic test_port_disable_bit,
   output logic chip_reset,
   output logic prog_mode,
   output logic [14:0] flash_cmd,
   output logic flash_cmd_clk,
   input wire logic [14:0] flash_result,
   output logic page_wr,
   output logic [7:0] page_wr_addr,
   output logic [7:0] page_wr_data,
   output logic page_rd,
   output logic [7:0] page_rd_addr,
   input wire logic [7:0] page_rd_data
);
   // chip-clock side: disable bit and its reset-driven clear
   logic ext_reset_s;
   logic [1:0] clr_cnt;
   jfp_sync u_ext_sync (.clock(clock), .nrst(nrst), .d(~ext_reset_n), .q(ext_reset_s));
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         test_port_disable_bit <= 1'b0;
         clr_cnt <= 2'h0;
      end else if (test_port_disable_bit && ext_reset_s) begin
         clr_cnt <= clr_cnt + 2'h1;
         if (clr_cnt == 2'(jfp_pkg::disable_clear_clocks - 1)) begin // R2
            test_port_disable_bit <= 1'b0;
            clr_cnt <= 2'h0;
         end
      end else begin
         clr_cnt <= 2'h0;
         if (test_port_disable_set) begin
            test_port_disable_bit <= 1'b1;
         end
      end
   end
   wire port_ok = test_port_enable_fuse && !test_port_disable_bit; // R1
   // port_ok crosses to tck domain
   logic ok_t1, ok_t;
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         ok_t1 <= 1'b0;
         ok_t <= 1'b0;
      end else begin
         ok_t1 <= port_ok;
         ok_t <= ok_t1;
      end
   end
   // tap controller
   jfp_pkg::jfp_tap_t st, next_st;
   always_comb begin
      next_st = st;
      case (st)
         jfp_pkg::jfp_tlr: next_st = tms ? jfp_pkg::jfp_tlr : jfp_pkg::jfp_rti;
         jfp_pkg::jfp_rti: next_st = tms ? jfp_pkg::jfp_sel_dr : jfp_pkg::jfp_rti;
         jfp_pkg::jfp_sel_dr: next_st = tms ? jfp_pkg::jfp_sel_ir : jfp_pkg::jfp_cap_dr;
         jfp_pkg::jfp_cap_dr: next_st = tms ? jfp_pkg::jfp_ex1_dr : jfp_pkg::jfp_sh_dr;
         jfp_pkg::jfp_sh_dr: next_st = tms ? jfp_pkg::jfp_ex1_dr : jfp_pkg::jfp_sh_dr;
         jfp_pkg::jfp_ex1_dr: next_st = tms ? jfp_pkg::jfp_up_dr : jfp_pkg::jfp_pa_dr;
         jfp_pkg::jfp_pa_dr: next_st = tms ? jfp_pkg::jfp_ex2_dr : jfp_pkg::jfp_pa_dr;
         jfp_pkg::jfp_ex2_dr: next_st = tms ? jfp_pkg::jfp_up_dr : jfp_pkg::jfp_sh_dr;
         jfp_pkg::jfp_up_dr: next_st = tms ? jfp_pkg::jfp_sel_dr : jfp_pkg::jfp_rti;
         jfp_pkg::jfp_sel_ir: next_st = tms ? jfp_pkg::jfp_tlr : jfp_pkg::jfp_cap_ir;
         jfp_pkg::jfp_cap_ir: next_st = tms ? jfp_pkg::jfp_ex1_ir : jfp_pkg::jfp_sh_ir;
         jfp_pkg::jfp_sh_ir: next_st = tms ? jfp_pkg::jfp_ex1_ir : jfp_pkg::jfp_sh_ir;
         jfp_pkg::jfp_ex1_ir: next_st = tms ? jfp_pkg::jfp_up_ir : jfp_pkg::jfp_pa_ir;
         jfp_pkg::jfp_pa_ir: next_st = tms ? jfp_pkg::jfp_ex2_ir : jfp_pkg::jfp_pa_ir;
         jfp_pkg::jfp_ex2_ir: next_st = tms ? jfp_pkg::jfp_up_ir : jfp_pkg::jfp_sh_ir;
         jfp_pkg::jfp_up_ir: next_st = tms ? jfp_pkg::jfp_sel_dr : jfp_pkg::jfp_rti;
         default: next_st = jfp_pkg::jfp_tlr;
      endcase
   end
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         st <= jfp_pkg::jfp_tlr;
      end else if (!ok_t) begin
         st <= jfp_pkg::jfp_tlr;
      end else begin
         st <= next_st;
      end
   end
   wire in_cap_dr = st == jfp_pkg::jfp_cap_dr;
   wire in_sh_dr = st == jfp_pkg::jfp_sh_dr;
   wire in_up_dr = st == jfp_pkg::jfp_up_dr;
   wire in_rti = st == jfp_pkg::jfp_rti;
   // instruction register
   logic [3:0] ir, ir_sh;
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         ir <= 4'h0;
         ir_sh <= 4'h0;
      end else if (st == jfp_pkg::jfp_tlr) begin
         ir <= 4'h0;
      end else if (st == jfp_pkg::jfp_cap_ir) begin
         ir_sh <= jfp_pkg::ir_capture_value;
      end else if (st == jfp_pkg::jfp_sh_ir) begin
         ir_sh <= {tdi, ir_sh[3:1]}; // R3 R4
      end else if (st == jfp_pkg::jfp_up_ir) begin
         ir <= ir_sh;
      end
   end
   wire sel_rst = ir == jfp_pkg::ir_chip_reset_instr; // R6
   wire sel_unl = ir == jfp_pkg::ir_program_unlock_instr; // R9
   wire sel_cmd = ir == jfp_pkg::ir_program_command_instr; // R12
   wire sel_fill = ir == jfp_pkg::ir_page_fill_instr; // R15
   wire sel_dump = ir == jfp_pkg::ir_page_dump_instr; // R17
   // data registers
   logic rst_chain;
   logic [15:0] unl;
   logic [14:0] cmd_sh;
   logic [7:0] pg_sh;
   logic [2:0] bit_cnt;
   logic [7:0] byte_cnt;
   logic prog_t;
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         rst_chain <= 1'b0;
         unl <= jfp_pkg::unlock_reset; // R11
         prog_t <= 1'b0;
         cmd_sh <= jfp_pkg::cmd_reset;
         flash_cmd <= jfp_pkg::cmd_reset;
      end else begin
         if (sel_rst && in_sh_dr) begin
            rst_chain <= tdi; // R6
         end
         if (sel_unl && in_sh_dr) begin
            unl <= {tdi, unl[15:1]}; // R3 R9
         end
         if (sel_unl && in_up_dr) begin
            prog_t <= unl == jfp_pkg::unlock_signature; // R10 R22
         end
         if (sel_cmd && in_cap_dr) begin
            cmd_sh <= flash_result; // R12
         end else if (sel_cmd && in_sh_dr) begin
            cmd_sh <= {tdi, cmd_sh[14:1]}; // R13
         end
         if (sel_cmd && in_up_dr && prog_t) begin
            flash_cmd <= cmd_sh; // R13 R22
         end
      end
   end
   assign prog_mode = prog_t;
   // one internal clock per idle visit: rising on entry, falling on next tck
   logic rti_d;
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         rti_d <= 1'b0;
      end else begin
         rti_d <= in_rti;
      end
   end
   assign flash_cmd_clk = sel_cmd && prog_t && in_rti && !rti_d; // R5 R14
   // virtual page chains
   wire pg_active = (sel_fill || sel_dump) && in_sh_dr && prog_t;
   wire byte_done = bit_cnt == 3'(jfp_pkg::byte_width - 1);
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         pg_sh <= 8'h00;
         bit_cnt <= 3'h0;
         byte_cnt <= 8'h00;
         page_wr <= 1'b0;
         page_wr_addr <= 8'h00;
         page_wr_data <= 8'h00;
      end else begin
         page_wr <= 1'b0;
         if (in_cap_dr) begin
            bit_cnt <= 3'h0;
            byte_cnt <= 8'h00;
         end else if (pg_active) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (sel_fill) begin
               pg_sh <= {tdi, pg_sh[7:1]}; // R3
               if (byte_done) begin
                  page_wr <= 1'b1; // R16
                  page_wr_addr <= byte_cnt;
                  page_wr_data <= {tdi, pg_sh[7:1]};
                  byte_cnt <= byte_cnt + 8'h01;
               end
            end else if (byte_done) begin
               // leftover byte goes out first, then page bytes 0 upward
               pg_sh <= page_rd_data; // R18
               byte_cnt <= byte_cnt + 8'h01;
            end else begin
               pg_sh <= {1'b0, pg_sh[7:1]}; // R18
            end
         end
      end
   end
   assign page_rd = sel_dump && pg_active && byte_done;
   assign page_rd_addr = byte_cnt;
   // tdo mux, updated on falling tck
   wire tdo_next = sel_rst ? rst_chain :
                   sel_unl ? unl[0] :
                   sel_cmd ? cmd_sh[0] :
                   (sel_fill || sel_dump) ? pg_sh[0] : 1'b0;
   wire ir_shift = st == jfp_pkg::jfp_sh_ir;
   always_ff @(negedge tck or negedge nrst) begin
      if (!nrst) begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else begin
         tdo <= ir_shift ? ir_sh[0] : tdo_next; // R3
         tdo_oe_n <= !(ir_shift || in_sh_dr);
      end
   end
   // reset chain and time-out, in chip-clock domain
   logic rst_s;
   logic [15:0] tmo;
   jfp_sync u_rst_sync (.clock(clock), .nrst(nrst), .d(rst_chain), .q(rst_s));
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tmo <= 16'h0000;
      end else if (rst_s) begin
         tmo <= 16'(reset_timeout); // R8
      end else if (tmo != 16'h0000) begin
         tmo <= tmo - 16'h0001;
      end
   end
   assign chip_reset = rst_chain || rst_s || (tmo != 16'h0000); // R7 R8
   // checks in the tck domain
   sequence s_fill_last_bit;
      sel_fill && pg_active && byte_done;
   endsequence
   sequence s_dump_last_bit;
      sel_dump && pg_active && byte_done;
   endsequence
   property p_unlock;
      @(posedge tck) disable iff (!nrst)
      (sel_unl && in_up_dr) |=> (prog_t == ($past(unl) == jfp_pkg::unlock_signature));
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock compare wrong"); // R10
   property p_cmdapply;
      @(posedge tck) disable iff (!nrst)
      (sel_cmd && in_up_dr && !prog_t) |=> $stable(flash_cmd);
   endproperty
   a_cmdapply: assert property (p_cmdapply) else $error("command applied while locked"); // R22
   property p_capture;
      @(posedge tck) disable iff (!nrst)
      (sel_cmd && in_cap_dr) |=> cmd_sh == $past(flash_result);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed result"); // R12
   property p_reset_now;
      @(posedge tck) disable iff (!nrst)
      rst_chain |-> chip_reset;
   endproperty
   a_reset_now: assert property (p_reset_now) else $error("reset not immediate"); // R7
   property p_oneclk;
      @(posedge tck) disable iff (!nrst)
      flash_cmd_clk |=> !flash_cmd_clk;
   endproperty
   a_oneclk: assert property (p_oneclk) else $error("more than one internal clock"); // R14
   property p_fill;
      @(posedge tck) disable iff (!nrst)
      s_fill_last_bit |=> page_wr && page_wr_data[7] == $past(tdi)
         && page_wr_addr == $past(byte_cnt);
   endproperty
   a_fill: assert property (p_fill) else $error("page byte not written"); // R16
   property p_shift;
      @(posedge tck) disable iff (!nrst)
      (sel_unl && in_sh_dr) |=> unl[15] == $past(tdi);
   endproperty
   a_shift: assert property (p_shift) else $error("unlock shift wrong"); // R3
   property p_dump_step;
      @(posedge tck) disable iff (!nrst)
      s_dump_last_bit |=> byte_cnt == $past(byte_cnt) + 8'h01;
   endproperty
   a_dump_step: assert property (p_dump_step) else $error("page byte fetched twice"); // R18
   property p_dump_hold;
      @(posedge tck) disable iff (!nrst)
      (sel_dump && in_cap_dr) |=> $stable(pg_sh);
   endproperty
   a_dump_hold: assert property (p_dump_hold) else $error("dump chain loaded at capture"); // R17
   property p_tap_kept;
      @(posedge tck) disable iff (!nrst)
      (sel_rst && in_sh_dr && ok_t) |=> st != jfp_pkg::jfp_tlr;
   endproperty
   a_tap_kept: assert property (p_tap_kept) else $error("reset chain reset the tap"); // R6
   property p_locked_wr;
      @(posedge tck) disable iff (!nrst)
      !prog_t |=> !page_wr;
   endproperty
   a_locked_wr: assert property (p_locked_wr) else $error("page written while locked"); // R22
   property p_drive;
      @(negedge tck) disable iff (!nrst)
      (ir_shift || in_sh_dr) |=> !tdo_oe_n;
   endproperty
   a_drive: assert property (p_drive) else $error("tdo not driven in shift"); // R3

   // checks in the chip-clock domain
   sequence s_disable_held;
      (test_port_disable_bit && ext_reset_s) [*2];
   endsequence
   sequence s_timeout_tail;
      chip_reset [*2];
   endsequence
   property p_disclr;
      @(posedge clock) disable iff (!nrst)
      s_disable_held |=> !test_port_disable_bit;
   endproperty
   a_disclr: assert property (p_disclr) else $error("disable bit not cleared"); // R2
   property p_timeout;
      @(posedge clock) disable iff (!nrst)
      $fell(rst_s) |-> s_timeout_tail;
   endproperty
   a_timeout: assert property (p_timeout) else $error("reset time-out cut short"); // R8
endmodule // jfp_port
`default_nettype wire

// ===== src/jfp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module jfp_sync (
   input wire logic clock,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic s1;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1 <= 1'b0;
         q <= 1'b0;
      end else begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule // jfp_sync
`default_nettype wire
